/* File: hw/dspwm_pkg.sv */
package dspwm_pkg;
   localparam int AXI_AW = 8;
   localparam int CNT_W  = 16;
   localparam int PRE_W  = 10;
   localparam int FLAG_W = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_COUNT   = 8'h04;
   localparam logic [7:0] OFS_CMP_A   = 8'h08;
   localparam logic [7:0] OFS_CMP_B   = 8'h0c;
   localparam logic [7:0] OFS_CAPTURE = 8'h10;
   localparam logic [7:0] OFS_FLAGS   = 8'h14;
   localparam logic [7:0] OFS_PIN_DIR = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1c;

   // Control fields
   localparam int CTRL_WAVE_LSB  = 0;
   localparam int CTRL_COMA_LSB  = 4;
   localparam int CTRL_COMB_LSB  = 6;
   localparam int CTRL_CS_LSB    = 8;
   localparam int CTRL_W         = 11;
   localparam logic [10:0] CTRL_RESET = 11'h000;

   // Waveform mode codes
   localparam logic [3:0] WAVE_PC8         = 4'h1;
   localparam logic [3:0] WAVE_PC9         = 4'h2;
   localparam logic [3:0] WAVE_PC10        = 4'h3;
   localparam logic [3:0] WAVE_PFC_CAPTURE = 4'h8;
   localparam logic [3:0] WAVE_PFC_CMPA    = 4'h9;
   localparam logic [3:0] WAVE_PC_CAPTURE  = 4'ha;
   localparam logic [3:0] WAVE_PC_CMPA     = 4'hb;

   // Output mode codes
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_NONINV = 2'h2;
   localparam logic [1:0] COM_INV    = 2'h3;

   localparam logic [15:0] TOP_8BIT  = 16'h00ff;
   localparam logic [15:0] TOP_9BIT  = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] BOTTOM    = 16'h0000;
   localparam logic [15:0] FULL_MASK = 16'hffff;

   // Prescaler select and masks
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [9:0] PRE_MASK8    = 10'h007;
   localparam logic [9:0] PRE_MASK64   = 10'h03f;
   localparam logic [9:0] PRE_MASK256  = 10'h0ff;
   localparam logic [9:0] PRE_MASK1024 = 10'h3ff;

   // Flag, direction and status bits
   localparam int FLG_OVF     = 0;
   localparam int FLG_CMP_A   = 1;
   localparam int FLG_CMP_B   = 2;
   localparam int FLG_CAPTURE = 3;
   localparam int DIR_A       = 0;
   localparam int DIR_B       = 1;
   localparam int ST_DOWN     = 0;
   localparam int ST_OUT_A    = 1;
   localparam int ST_OUT_B    = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/dspwm_timer.sv */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dspwm_timer (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Compare output pins
   output logic             compare_output_a,
   output logic             compare_output_a_oe_n,
   output logic             compare_output_b,
   output logic             compare_output_b_oe_n
);
   logic [10:0] ctrl_reg;
   logic [15:0] count_value_reg;
   logic        count_down_reg;
   logic [15:0] compare_a_buf_reg;
   logic [15:0] compare_b_buf_reg;
   logic [15:0] compare_a_value_reg;
   logic [15:0] compare_b_value_reg;
   logic [15:0] capture_top_value_reg;
   logic [3:0]  flags_reg;
   logic [1:0]  pin_direction_bit_reg;
   logic [9:0]  prescale_reg;
   logic        out_a_reg;
   logic        out_b_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   logic [3:0]  waveform_mode_select;
   logic [1:0]  output_mode_a_select;
   logic [1:0]  output_mode_b_select;
   logic [2:0]  clock_select;
   logic [15:0] top_value;
   logic        pc_mode;
   logic        pfc_mode;
   logic        dual_mode;
   logic        fixed_top;
   logic        top_from_a;
   logic        top_from_capture;
   logic        tick;
   logic        adv;
   logic        at_top;
   logic        at_bottom;
   logic        eff_up;
   logic        match_a;
   logic        match_b;
   logic        load_cmp;
   logic        toggle_ok_a;
   logic [3:0]  flag_set;
   logic [3:0]  flag_clr;
   logic        have_aw;
   logic        have_w;
   logic        do_write;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [31:0] wr_mask;
   logic [31:0] wr_merged;
   logic [15:0] cmp_wr_value;

   assign waveform_mode_select = ctrl_reg[dspwm_pkg::CTRL_WAVE_LSB +: 4];
   assign output_mode_a_select = ctrl_reg[dspwm_pkg::CTRL_COMA_LSB +: 2];
   assign output_mode_b_select = ctrl_reg[dspwm_pkg::CTRL_COMB_LSB +: 2];
   assign clock_select         = ctrl_reg[dspwm_pkg::CTRL_CS_LSB +: 3];

   // Mode decode and top selection
   always_comb begin
      pc_mode          = 1'b0;
      pfc_mode         = 1'b0;
      fixed_top        = 1'b0;
      top_from_a       = 1'b0;
      top_from_capture = 1'b0;
      top_value        = dspwm_pkg::TOP_8BIT;
      case (waveform_mode_select)
         dspwm_pkg::WAVE_PC8: begin
            pc_mode   = 1'b1;
            fixed_top = 1'b1;
            top_value = dspwm_pkg::TOP_8BIT;
         end
         dspwm_pkg::WAVE_PC9: begin
            pc_mode   = 1'b1;
            fixed_top = 1'b1;
            top_value = dspwm_pkg::TOP_9BIT;
         end
         dspwm_pkg::WAVE_PC10: begin
            pc_mode   = 1'b1;
            fixed_top = 1'b1;
            top_value = dspwm_pkg::TOP_10BIT;
         end
         dspwm_pkg::WAVE_PC_CAPTURE: begin
            pc_mode          = 1'b1;
            top_from_capture = 1'b1;
            top_value        = capture_top_value_reg;
         end
         dspwm_pkg::WAVE_PC_CMPA: begin
            pc_mode    = 1'b1;
            top_from_a = 1'b1;
            top_value  = compare_a_value_reg;
         end
         dspwm_pkg::WAVE_PFC_CAPTURE: begin
            pfc_mode         = 1'b1;
            top_from_capture = 1'b1;
            top_value        = capture_top_value_reg;
         end
         dspwm_pkg::WAVE_PFC_CMPA: begin
            pfc_mode   = 1'b1;
            top_from_a = 1'b1;
            top_value  = compare_a_value_reg;
         end
         default: begin
            pc_mode = 1'b0;
         end
      endcase
   end
   assign dual_mode = pc_mode | pfc_mode;

   // Prescaler; free-running so a tick lands every N clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_reg <= '0;
      end else begin
         prescale_reg <= prescale_reg + 10'h001;
      end
   end

   always_comb begin
      case (clock_select)
         dspwm_pkg::CS_DIV1:    tick = 1'b1;
         dspwm_pkg::CS_DIV8:    tick = (prescale_reg & dspwm_pkg::PRE_MASK8) ==
                                       dspwm_pkg::PRE_MASK8;
         dspwm_pkg::CS_DIV64:   tick = (prescale_reg & dspwm_pkg::PRE_MASK64) ==
                                       dspwm_pkg::PRE_MASK64;
         dspwm_pkg::CS_DIV256:  tick = (prescale_reg & dspwm_pkg::PRE_MASK256) ==
                                       dspwm_pkg::PRE_MASK256;
         dspwm_pkg::CS_DIV1024: tick = prescale_reg == dspwm_pkg::PRE_MASK1024;
         default:               tick = 1'b0;
      endcase
   end

   assign adv       = tick & dual_mode;
   assign at_top    = count_value_reg == top_value;
   assign at_bottom = count_value_reg == dspwm_pkg::BOTTOM;
   // Top counts as falling, bottom as rising: gives the constant extremes
   assign eff_up    = at_bottom | (~count_down_reg & ~at_top);
   assign match_a   = adv & (count_value_reg == compare_a_value_reg);
   assign match_b   = adv & (count_value_reg == compare_b_value_reg);
   assign load_cmp  = adv & ((pc_mode & at_top) | (pfc_mode & at_bottom));
   assign toggle_ok_a = top_from_a;

   // Up/down counter; a missed top wraps through full scale
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value_reg <= dspwm_pkg::BOTTOM;
         count_down_reg  <= 1'b0;
      end else if (adv) begin
         if (!count_down_reg) begin
            if (at_top) begin
               count_down_reg  <= 1'b1;
               count_value_reg <= count_value_reg - 16'h0001;
            end else begin
               count_value_reg <= count_value_reg + 16'h0001;
            end
         end else if (at_bottom) begin
            count_down_reg  <= 1'b0;
            count_value_reg <= count_value_reg + 16'h0001;
         end else begin
            count_value_reg <= count_value_reg - 16'h0001;
         end
      end
   end

   // Compare buffers; fixed top masks bits beyond resolution
   assign cmp_wr_value = wr_merged[15:0] & (fixed_top ? top_value : dspwm_pkg::FULL_MASK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_a_buf_reg <= dspwm_pkg::BOTTOM;
         compare_b_buf_reg <= dspwm_pkg::BOTTOM;
      end else if (do_write) begin
         if (wr_addr == dspwm_pkg::OFS_CMP_A) begin
            compare_a_buf_reg <= cmp_wr_value;
         end
         if (wr_addr == dspwm_pkg::OFS_CMP_B) begin
            compare_b_buf_reg <= cmp_wr_value;
         end
      end
   end

   // Active compare values; outside dual-slope modes they follow at once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compare_a_value_reg <= dspwm_pkg::BOTTOM;
         compare_b_value_reg <= dspwm_pkg::BOTTOM;
      end else if (load_cmp || !dual_mode) begin
         compare_a_value_reg <= compare_a_buf_reg;
         compare_b_value_reg <= compare_b_buf_reg;
      end
   end

   // Waveform outputs, changed only on a match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_a_reg <= 1'b0;
         out_b_reg <= 1'b0;
      end else begin
         if (match_a) begin
            case (output_mode_a_select)
               dspwm_pkg::COM_TOGGLE: out_a_reg <= out_a_reg ^ toggle_ok_a;
               dspwm_pkg::COM_NONINV: out_a_reg <= ~eff_up;
               dspwm_pkg::COM_INV:    out_a_reg <= eff_up;
               dspwm_pkg::COM_OFF:    out_a_reg <= out_a_reg;
            endcase
         end
         if (match_b) begin
            case (output_mode_b_select)
               dspwm_pkg::COM_NONINV: out_b_reg <= ~eff_up;
               dspwm_pkg::COM_INV:    out_b_reg <= eff_up;
               default:               out_b_reg <= out_b_reg;
            endcase
         end
      end
   end

   // Pins: driven only when connected and direction is output
   assign compare_output_a_oe_n = ~(pin_direction_bit_reg[dspwm_pkg::DIR_A] &
                                    (output_mode_a_select != dspwm_pkg::COM_OFF));
   assign compare_output_b_oe_n = ~(pin_direction_bit_reg[dspwm_pkg::DIR_B] &
                                    output_mode_b_select[1]);
   assign compare_output_a = out_a_reg & ~compare_output_a_oe_n;
   assign compare_output_b = out_b_reg & ~compare_output_b_oe_n;

   // Flags; a new event wins over a clear in the same cycle
   always_comb begin
      flag_set = '0;
      flag_set[dspwm_pkg::FLG_OVF]     = adv & at_bottom;
      flag_set[dspwm_pkg::FLG_CMP_A]   = match_a | (adv & at_top & top_from_a);
      flag_set[dspwm_pkg::FLG_CMP_B]   = match_b;
      flag_set[dspwm_pkg::FLG_CAPTURE] = adv & at_top & top_from_capture;
   end
   assign flag_clr = (do_write && wr_addr == dspwm_pkg::OFS_FLAGS) ?
                     (wr_data[3:0] & wr_mask[3:0]) : 4'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      end
   end

   // Register read view
   function automatic logic [31:0] reg_value(input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      case (a)
         dspwm_pkg::OFS_CTRL:    v[10:0] = ctrl_reg;
         dspwm_pkg::OFS_COUNT:   v[15:0] = count_value_reg;
         dspwm_pkg::OFS_CMP_A:   v[15:0] = compare_a_buf_reg;
         dspwm_pkg::OFS_CMP_B:   v[15:0] = compare_b_buf_reg;
         dspwm_pkg::OFS_CAPTURE: v[15:0] = capture_top_value_reg;
         dspwm_pkg::OFS_FLAGS:   v[3:0]  = flags_reg;
         dspwm_pkg::OFS_PIN_DIR: v[1:0]  = pin_direction_bit_reg;
         dspwm_pkg::OFS_STATUS:  v[2:0]  = {out_b_reg, out_a_reg, count_down_reg};
         default:                v       = '0;
      endcase
      return v;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return a <= dspwm_pkg::OFS_STATUS;
   endfunction

   // AXI4-Lite write path; address and data may come in either order
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
   assign have_aw  = aw_held_reg | (s_axi_awvalid & s_axi_awready);
   assign have_w   = w_held_reg | (s_axi_wvalid & s_axi_wready);
   assign do_write = have_aw & have_w;
   assign wr_addr  = {(aw_held_reg ? aw_addr_reg[7:2] : s_axi_awaddr[7:2]), 2'b00};
   assign wr_data  = w_held_reg ? w_data_reg : s_axi_wdata;
   assign wr_mask  = {{8{(w_held_reg ? w_strb_reg[3] : s_axi_wstrb[3])}},
                      {8{(w_held_reg ? w_strb_reg[2] : s_axi_wstrb[2])}},
                      {8{(w_held_reg ? w_strb_reg[1] : s_axi_wstrb[1])}},
                      {8{(w_held_reg ? w_strb_reg[0] : s_axi_wstrb[0])}}};
   // Process, not assign: the function reads registers beyond its argument
   always_comb begin
      wr_merged = (reg_value(wr_addr) & ~wr_mask) | (wr_data & wr_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= dspwm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= is_mapped(wr_addr) ? dspwm_pkg::RESP_OKAY : dspwm_pkg::RESP_SLVERR;
         end else begin
            aw_held_reg <= have_aw;
            w_held_reg  <= have_w;
            if (s_axi_bready) begin
               bvalid_reg <= 1'b0;
            end
         end
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg              <= dspwm_pkg::CTRL_RESET;
         capture_top_value_reg <= dspwm_pkg::BOTTOM;
         pin_direction_bit_reg <= '0;
      end else if (do_write) begin
         case (wr_addr)
            dspwm_pkg::OFS_CTRL:    ctrl_reg              <= wr_merged[10:0];
            dspwm_pkg::OFS_CAPTURE: capture_top_value_reg <= wr_merged[15:0];
            dspwm_pkg::OFS_PIN_DIR: pin_direction_bit_reg <= wr_merged[1:0];
            default:                ctrl_reg              <= ctrl_reg;
         endcase
      end
   end

   // AXI4-Lite read path
   assign s_axi_arready = ~rvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= dspwm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= reg_value({s_axi_araddr[7:2], 2'b00});
         rresp_reg  <= is_mapped({s_axi_araddr[7:2], 2'b00}) ?
                       dspwm_pkg::RESP_OKAY : dspwm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_top_reverse: assert property (
      adv && !count_down_reg && at_top && top_value != dspwm_pkg::BOTTOM |=>
         count_down_reg && count_value_reg == $past(count_value_reg) - 16'h0001)
      else $error("counter did not turn at top");

   chk_count_rise: assert property (
      adv && !count_down_reg && !at_top |=> count_value_reg == $past(count_value_reg) + 16'h0001)
      else $error("counter did not rise by one");

   chk_tick_hold: assert property (
      !adv |=> $stable(count_value_reg) && $stable(count_down_reg))
      else $error("counter moved without tick");

   chk_ovf_bottom: assert property (
      adv && at_bottom |=> flags_reg[dspwm_pkg::FLG_OVF])
      else $error("overflow flag missed at bottom");

   chk_pfc_load: assert property (
      adv && pfc_mode && at_bottom |=> compare_b_value_reg == $past(compare_b_buf_reg)
         && flags_reg[dspwm_pkg::FLG_OVF])
      else $error("bottom load missing");

   chk_pc_load: assert property (
      adv && pc_mode && at_top && top_from_capture |=>
         compare_a_value_reg == $past(compare_a_buf_reg) && flags_reg[dspwm_pkg::FLG_CAPTURE])
      else $error("top load or flag missing");

   chk_match_flag: assert property (
      match_b |=> flags_reg[dspwm_pkg::FLG_CMP_B])
      else $error("compare flag missed");

   chk_noninv_level: assert property (
      match_a && output_mode_a_select == dspwm_pkg::COM_NONINV |=> out_a_reg == $past(~eff_up))
      else $error("non-inverted level wrong");

   chk_toggle_a: assert property (
      match_a && top_from_a && output_mode_a_select == dspwm_pkg::COM_TOGGLE |=>
         out_a_reg != $past(out_a_reg))
      else $error("toggle missed");

   chk_pin_gate: assert property (
      !pin_direction_bit_reg[dspwm_pkg::DIR_A] |-> compare_output_a_oe_n && !compare_output_a)
      else $error("pin driven without direction");

   chk_mask_write: assert property (
      do_write && fixed_top && wr_addr == dspwm_pkg::OFS_CMP_A |=>
         (compare_a_buf_reg & ~$past(top_value)) == dspwm_pkg::BOTTOM)
      else $error("compare bits beyond resolution kept");

   chk_pc_hold_cmp: assert property (
      adv && pc_mode && !at_top |=>
         $stable(compare_a_value_reg) && $stable(compare_b_value_reg))
      else $error("compare value changed away from top");
endmodule
`default_nettype wire

/* File: verification/dspwm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, rd;
   logic        compare_output_a, compare_output_a_oe_n, compare_output_b, compare_output_b_oe_n;
   logic [31:0] seed = 32'h1a76efdc;
   int          bad_count = 0, num_checks = 0, cycles = 0, t;

   dspwm_timer i_dspwm_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .compare_output_a, .compare_output_a_oe_n,
      .compare_output_b, .compare_output_b_oe_n);

   always #2.5 aclk = ~aclk;

   function automatic int rv(int n);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return int'(seed % 32'(n));
   endfunction

   // High clocks over two periods of the dual slope
   function automatic int ehi(logic [1:0] cm, int c, int tp, int dv);
      case (cm)
         2'h1: return 2 * tp * dv;
         2'h2: return 4 * c * dv;
         2'h3: return 4 * (tp - c) * dv;
         default: return 0;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 70000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic run(input logic [3:0] md, input logic [2:0] cs, input int dv, input int tp,
         input int ca, input logic [1:0] cma, input int cb, input logic [1:0] cmb);
      int per, ha, hb;
      per = 2 * tp * dv;
      ha = 0;
      hb = 0;
      rst();
      wr(dspwm_pkg::OFS_CMP_A, 32'(ca));
      wr(dspwm_pkg::OFS_CMP_B, 32'(cb));
      wr(dspwm_pkg::OFS_CAPTURE, 32'(tp));
      wr(dspwm_pkg::OFS_PIN_DIR, 32'h3);
      wr(dspwm_pkg::OFS_CTRL, {21'h0, cs, cmb, cma, md});
      // Settle first, then measure whole periods so phase drops out
      repeat (2 * per) @(posedge aclk);
      repeat (2 * per) begin
         @(posedge aclk);
         ha += int'(compare_output_a === 1'h1);
         hb += int'(compare_output_b === 1'h1);
      end
      chk("pin a high", 32'(ehi(cma, ca, tp, dv)), 32'(ha));
      chk("pin b high", 32'(ehi(cmb == 2'h1 ? 2'h0 : cmb, cb, tp, dv)), 32'(hb));
      chk("oe a", {31'h0, cma == 2'h0}, {31'h0, compare_output_a_oe_n});
      chk("oe b", {31'h0, !cmb[1]}, {31'h0, compare_output_b_oe_n});
      rdr(dspwm_pkg::OFS_FLAGS);
      chk("read resp", 32'(dspwm_pkg::RESP_OKAY), {30'h0, rs});
      chk("flags", {28'h0, md == 4'h8 || md == 4'ha, 3'h7}, rd);
      wr(dspwm_pkg::OFS_CTRL, {24'h0, cmb, cma, md});
      wr(dspwm_pkg::OFS_FLAGS, 32'hf);
      wr(dspwm_pkg::OFS_PIN_DIR, 32'h0);
      rdr(dspwm_pkg::OFS_FLAGS);
      chk("flags cleared", 32'h0, rd);
      chk("pins off", 32'ha, {28'h0, compare_output_a_oe_n, compare_output_a,
         compare_output_b_oe_n, compare_output_b});
      $display("test mode %0d done", md);
   endtask

   initial begin
      rst();
      chk("pins at reset", 32'ha, {28'h0, compare_output_a_oe_n, compare_output_a,
         compare_output_b_oe_n, compare_output_b});
      rdr(dspwm_pkg::OFS_CTRL);
      chk("ctrl reset", 32'h0, rd);
      rdr(8'h20);
      chk("unmapped read", 32'h2, {rd[29:0], rs});
      wr(8'h24, 32'h5);
      chk("unmapped write", 32'h2, {30'h0, rs});
      for (int i = 1; i <= 3; i++) begin
         wr(dspwm_pkg::OFS_CTRL, 32'(i));
         wr(dspwm_pkg::OFS_CMP_A, 32'hffff);
         rdr(dspwm_pkg::OFS_CMP_A);
         chk("masked compare", 32'((1 << (7 + i)) - 1), rd);
      end
      $display("test registers done");
      run(4'h1, 3'h1, 1, 255, rv(256), 2'h2, rv(256), 2'h3);
      run(4'h2, 3'h1, 1, 511, 0, 2'h2, 511, 2'h2);
      run(4'h3, 3'h1, 1, 1023, 1023, 2'h3, 0, 2'h3);
      t = 4 + rv(40);
      run(4'ha, 3'h2, 8, t, rv(t + 1), 2'h2, rv(t + 1), 2'h3);
      t = 3 + rv(60);
      run(4'hb, 3'h1, 1, t, t, 2'h1, rv(t + 1), 2'h2);
      run(4'h8, 3'h3, 64, 3, 0, 2'h2, 3, 2'h2);
      run(4'h9, 3'h4, 256, 3, 3, 2'h1, 2, 2'h1);
      run(4'h8, 3'h5, 1024, 3, 2, 2'h3, 1, 2'h2);
      finish_test();
   end
endmodule
`default_nettype wire
